/* rtl/urs_pkg.sv */
// constants shared by the receive-status block
package urs_pkg;
    // ========================================
    // register byte addresses
    localparam logic [7:0] ADDR_STA = 8'h00; // status and control
    localparam logic [7:0] ADDR_MODE = 8'h04; // character format
    localparam logic [7:0] ADDR_DIV = 8'h08; // clocks per bit
    localparam logic [7:0] ADDR_DATA = 8'h0C; // receive data, read pops
    localparam logic [7:0] ADDR_ISTAT = 8'h10; // sticky events, write one clears
    localparam logic [7:0] ADDR_IMASK = 8'h14; // event mask
    // ========================================
    // status and control bit positions
    localparam int BIT_ADDRESS_DETECT_ENABLE = 5;
    localparam int BIT_RECEIVER_IDLE_FLAG = 4;
    localparam int BIT_PARITY_ERROR_FLAG = 3;
    localparam int BIT_FRAMING_ERROR_FLAG = 2;
    localparam int BIT_OVERRUN_ERROR_FLAG = 1;
    localparam int BIT_RX_DATA_AVAILABLE = 0;
    // ========================================
    // event bit positions in status and mask
    localparam int EV_RX = 0;
    localparam int EV_OVR = 1;
    localparam int EV_PAR = 2;
    localparam int EV_FRM = 3;
    localparam int EV_W = 4;
    // ========================================
    // character formats
    localparam logic [1:0] MODE_8N = 2'h0;
    localparam logic [1:0] MODE_8E = 2'h1;
    localparam logic [1:0] MODE_8O = 2'h2;
    localparam logic [1:0] MODE_9N = 2'h3;
    // ========================================
    // sizes and reset values
    localparam int DATA_W = 9; // widest character
    localparam int ENTRY_W = 11; // framing, parity, data
    localparam int FIFO_D = 4;
    localparam int CNT_W = 3; // holds 0..FIFO_D
    localparam logic [15:0] DIV_RST = 16'h0010;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    // ========================================
    // receiver states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PAR = 5'h08,
        ST_STOP = 5'h10
    } urs_state_e;
endpackage

/* rtl/urs_fifo.sv */
// small receive fifo with flush and head view
`timescale 1ns/1ns
module urs_fifo #(
    parameter int W = 11,
    parameter int D = 4,
    parameter int CW = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    input wire logic [W-1:0] wdata,
    // state
    output logic [W-1:0] head,
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    // storage array and pointers
    logic [W-1:0] mem [D];
    logic [CW-2:0] rd_ptr_reg;
    logic [CW-2:0] wr_ptr_reg;
    logic [CW-1:0] cnt_reg;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign head = mem[rd_ptr_reg];
    assign count = cnt_reg;
    assign full = (cnt_reg == CW'(D));
    assign empty = (cnt_reg == '0);

    // ========================================
    // pointers; flush beats any push or pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
        end
    end

    // ========================================
    // data array, no reset needed
    always_ff @(posedge pclk) begin
        if (do_push && !flush) begin
            mem[wr_ptr_reg] <= wdata;
        end
    end
endmodule

/* rtl/urs_top.sv */
// uart receiver with status flags, address detect and apb registers
// Function
// R1: address detect keeps characters with ninth bit set
// R2: address detect only acts in nine-bit mode
// R3: read-only idle flag, one when not receiving
// R4: parity error flag describes fifo head character
// R5: framing error flag describes fifo head character
// R6: overrun set on overflow, software reads or clears
// R7: clearing overrun empties buffer and shift register
// R8: data-available flag one while fifo not empty
// R9: error flags follow head as fifo advances
`timescale 1ns/1ns
module urs_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line and interrupt
    input wire logic rx,
    output logic irq
);
    // ========================================
    // declarations
    urs_pkg::urs_state_e state_reg, state_next; // receiver state
    logic [15:0] bit_cnt_reg; // clocks left in current bit
    logic [3:0] nbits_reg; // data bits taken so far
    logic [8:0] rsr_reg; // receive shift register
    logic par_reg; // running parity
    logic parity_error_flag_reg; // parity result of current char
    logic address_detect_enable_reg; // address detect enable
    logic overrun_error_flag_reg; // overrun flag
    logic [1:0] mode_reg; // character format
    logic [15:0] div_reg; // clocks per bit
    logic [urs_pkg::EV_W-1:0] ist_reg; // sticky events
    logic [urs_pkg::EV_W-1:0] imask_reg; // event mask
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic [urs_pkg::ENTRY_W-1:0] head; // fifo head entry
    logic [urs_pkg::CNT_W-1:0] count;
    logic full;
    logic empty;

    // ========================================
    // apb decode; no wait state, pready raised in the access cycle
    wire acc = psel && penable && pready_reg; // completing transfer
    wire wr_acc = acc && pwrite;
    wire rd_acc = acc && !pwrite;
    wire hit_sta = (paddr == urs_pkg::ADDR_STA);
    wire hit_mode = (paddr == urs_pkg::ADDR_MODE);
    wire hit_div = (paddr == urs_pkg::ADDR_DIV);
    wire hit_data = (paddr == urs_pkg::ADDR_DATA);
    wire hit_ist = (paddr == urs_pkg::ADDR_ISTAT);
    wire hit_imask = (paddr == urs_pkg::ADDR_IMASK);
    wire mapped = hit_sta | hit_mode | hit_div | hit_data | hit_ist | hit_imask;

    // ========================================
    // receiver timing
    wire bit_done = (bit_cnt_reg == 16'h0000); // sample point reached
    wire [15:0] half_div = {1'b0, div_reg[15:1]};
    wire mode9 = (mode_reg == urs_pkg::MODE_9N);
    wire has_par = (mode_reg == urs_pkg::MODE_8E) || (mode_reg == urs_pkg::MODE_8O);
    wire [3:0] nbits_want = mode9 ? urs_pkg::BITS_9 : urs_pkg::BITS_8;
    wire in_idle = (state_reg == urs_pkg::ST_IDLE);
    wire char_done = (state_reg == urs_pkg::ST_STOP) && bit_done;
    wire frame_err = char_done && !rx; // stop bit must be high
    // data bits arrive lsb first; eight-bit characters sit low
    wire [8:0] char_data = mode9 ? rsr_reg : {1'b0, rsr_reg[8:1]};

    // ========================================
    // address detect: drop data characters, keep address ones
    wire addr_only = address_detect_enable_reg && mode9; // R2
    wire keep_char = !addr_only || char_data[8]; // R1
    wire want_push = char_done && keep_char;
    // while overrun stands nothing new is stored
    wire push = want_push && !full && !overrun_error_flag_reg;
    wire overflow = want_push && full && !overrun_error_flag_reg; // R6

    // ========================================
    // software side effects
    wire pop = rd_acc && hit_data; // R9
    // overrun clears only on a one to zero write
    wire ovr_clear = wr_acc && hit_sta && overrun_error_flag_reg && !pwdata[urs_pkg::BIT_OVERRUN_ERROR_FLAG];
    wire [urs_pkg::ENTRY_W-1:0] entry = {frame_err, parity_error_flag_reg, char_data};
    wire head_parity_error_flag = !empty && head[urs_pkg::DATA_W]; // R4
    wire head_framing_error_flag = !empty && head[urs_pkg::DATA_W+1]; // R5
    // an empty fifo reads as zero, never a stale or never-written slot
    wire [urs_pkg::DATA_W-1:0] head_data = empty ? '0 : head[urs_pkg::DATA_W-1:0];

    // event sources for the interrupt status
    logic [urs_pkg::EV_W-1:0] ev;
    assign ev[urs_pkg::EV_RX] = push;
    assign ev[urs_pkg::EV_OVR] = overflow;
    assign ev[urs_pkg::EV_PAR] = push && parity_error_flag_reg;
    assign ev[urs_pkg::EV_FRM] = push && frame_err;
    wire [urs_pkg::EV_W-1:0] ist_clr = (wr_acc && hit_ist) ?
        pwdata[urs_pkg::EV_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [urs_pkg::EV_W-1:0] ist_next = (ist_reg & ~ist_clr) | ev;

    // status word as software sees it
    wire [15:0] sta_word = {10'h000, address_detect_enable_reg, in_idle, head_parity_error_flag, head_framing_error_flag,
        overrun_error_flag_reg, !empty}; // R3 R8
    // read multiplexer; unmapped reads return zero
    wire [31:0] rd_mux =
        hit_sta ? {16'h0000, sta_word} :
        hit_mode ? {30'h00000000, mode_reg} :
        hit_div ? {16'h0000, div_reg} :
        hit_data ? {23'h000000, head_data} :
        hit_ist ? {28'h0000000, ist_reg} :
        hit_imask ? {28'h0000000, imask_reg} : 32'h00000000;

    // ========================================
    // receive fifo
    urs_fifo #(
        .W(urs_pkg::ENTRY_W),
        .D(urs_pkg::FIFO_D),
        .CW(urs_pkg::CNT_W)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .push(push),
        .pop(pop),
        .flush(ovr_clear), // R7
        .wdata(entry),
        .head(head),
        .count(count),
        .full(full),
        .empty(empty)
    );

    // ========================================
    // receiver next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            urs_pkg::ST_IDLE: begin
                if (!rx) begin
                    state_next = urs_pkg::ST_START;
                end
            end
            urs_pkg::ST_START: begin
                // a glitch shorter than half a bit is ignored
                if (bit_done) begin
                    state_next = rx ? urs_pkg::ST_IDLE : urs_pkg::ST_DATA;
                end
            end
            urs_pkg::ST_DATA: begin
                if (bit_done && (nbits_reg + 4'h1 == nbits_want)) begin
                    state_next = has_par ? urs_pkg::ST_PAR : urs_pkg::ST_STOP;
                end
            end
            urs_pkg::ST_PAR: begin
                if (bit_done) begin
                    state_next = urs_pkg::ST_STOP;
                end
            end
            urs_pkg::ST_STOP: begin
                if (bit_done) begin
                    state_next = urs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = urs_pkg::ST_IDLE;
            end
        endcase
        // flush also drops a character in flight
        if (ovr_clear) begin
            state_next = urs_pkg::ST_IDLE; // R7
        end
    end

    // ========================================
    // receiver state register and bit timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= urs_pkg::ST_IDLE;
            bit_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (in_idle) begin
                bit_cnt_reg <= half_div; // aim at the middle of start
            end else if (bit_done) begin
                bit_cnt_reg <= div_reg - 16'h0001;
            end else begin
                bit_cnt_reg <= bit_cnt_reg - 16'h0001;
            end
        end
    end

    // ========================================
    // shift register, bit count and parity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsr_reg <= 9'h000;
            nbits_reg <= 4'h0;
            par_reg <= 1'b0;
            parity_error_flag_reg <= 1'b0;
        end else if (ovr_clear || in_idle) begin
            rsr_reg <= 9'h000; // R7
            nbits_reg <= 4'h0;
            par_reg <= (mode_reg == urs_pkg::MODE_8O); // odd seeds with one
            parity_error_flag_reg <= 1'b0;
        end else if (bit_done && state_reg == urs_pkg::ST_DATA) begin
            rsr_reg <= {rx, rsr_reg[8:1]};
            nbits_reg <= nbits_reg + 4'h1;
            par_reg <= par_reg ^ rx;
        end else if (bit_done && state_reg == urs_pkg::ST_PAR) begin
            parity_error_flag_reg <= par_reg ^ rx;
        end
    end

    // ========================================
    // overrun flag; software may only clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_error_flag_reg <= 1'b0;
        end else if (overflow) begin
            overrun_error_flag_reg <= 1'b1; // R6
        end else if (ovr_clear) begin
            overrun_error_flag_reg <= 1'b0;
        end
    end

    // ========================================
    // writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_detect_enable_reg <= 1'b0;
            mode_reg <= urs_pkg::MODE_8N;
            div_reg <= urs_pkg::DIV_RST;
            imask_reg <= '0;
        end else if (wr_acc) begin
            if (hit_sta) begin
                address_detect_enable_reg <= pwdata[urs_pkg::BIT_ADDRESS_DETECT_ENABLE];
            end
            if (hit_mode) begin
                mode_reg <= pwdata[1:0];
            end
            if (hit_div) begin
                div_reg <= pwdata[15:0];
            end
            if (hit_imask) begin
                imask_reg <= pwdata[urs_pkg::EV_W-1:0];
            end
        end
    end

    // ========================================
    // interrupt status and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            ist_reg <= ist_next;
            irq_reg <= |(ist_next & imask_reg);
        end
    end

    // ========================================
    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable && !pready_reg;
            if (psel && !penable) begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_reg <= !mapped;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

    // ========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_sta_setup = psel && !penable && !pwrite && hit_sta;
    wire rd_data_setup = psel && !penable && !pwrite && hit_data;

    a_addr_filter: assert property (push |-> !(addr_only && !char_data[8])) // R1
        else $error("data character stored in address mode");
    a_nine_bit_only: assert property (char_done && !mode9 && !full && !overrun_error_flag_reg
        |-> push) // R2
        else $error("character dropped outside nine-bit mode");
    a_idle_flag: assert property (rd_sta_setup
        |=> prdata_reg[urs_pkg::BIT_RECEIVER_IDLE_FLAG] == $past(in_idle)) // R3
        else $error("idle flag wrong");
    a_parity_error_flag_head: assert property (rd_sta_setup
        |=> prdata_reg[urs_pkg::BIT_PARITY_ERROR_FLAG] == $past(!empty && head[urs_pkg::DATA_W])) // R4
        else $error("parity flag not from head");
    a_framing_error_flag_head: assert property (rd_sta_setup
        |=> prdata_reg[urs_pkg::BIT_FRAMING_ERROR_FLAG] == $past(!empty && head[urs_pkg::DATA_W+1])) // R5
        else $error("framing flag not from head");
    a_ovr_set: assert property (want_push && full && !ovr_clear |=> overrun_error_flag_reg) // R6
        else $error("overrun not flagged");
    a_ovr_flush: assert property (ovr_clear |=> empty && in_idle && !overrun_error_flag_reg) // R7
        else $error("overrun clear did not flush");
    a_data_avail: assert property (rd_sta_setup
        |=> prdata_reg[urs_pkg::BIT_RX_DATA_AVAILABLE] == $past(!empty)) // R8
        else $error("data available wrong");
    a_pop_advance: assert property (pop && !push && count > 3'h1
        |=> count == $past(count) - 3'h1) // R9
        else $error("head did not advance");

    // ========================================
    // guards on the overrun flag, empty reads and the bus answer
    a_ovr_sticky: assert property (overrun_error_flag_reg && !ovr_clear |=> overrun_error_flag_reg) // R6
        else $error("overrun flag dropped without a clear");
    a_ovr_blocks_store: assert property (overrun_error_flag_reg |-> !push) // R6
        else $error("character stored while overrun stands");
    a_empty_flags: assert property (empty |-> !head_parity_error_flag && !head_framing_error_flag) // R4 R5
        else $error("error flag shown without a character");
    a_empty_read: assert property (rd_data_setup && empty |=> prdata_reg == 32'h00000000)
        else $error("empty data read not zero");
    a_ready_pulse: assert property (pready_reg |=> !pready_reg)
        else $error("ready held for two cycles");
    a_event_keep: assert property (ist_reg[urs_pkg::EV_OVR] && !ist_clr[urs_pkg::EV_OVR]
        |=> ist_reg[urs_pkg::EV_OVR])
        else $error("overrun event dropped without a clear");

    c_push: cover property (push);
    c_overrun: cover property (overflow);
    c_flush: cover property (ovr_clear);
    c_irq: cover property (irq_reg);
    c_addr_drop: cover property (char_done && !keep_char);
endmodule

/* verification/urs_line_src.sv */
// serial line source model that drives the receive pin
`timescale 1ns/1ns
module urs_line_src (
    // clock
    input wire logic pclk,
    // serial line
    output logic rx
);
    // clocks per bit, kept equal to the divisor the bench programs
    int div = 8;
    // line rests high, as a pulled-up wire would
    initial rx = 1'b1;
    // ========================================
    // one bit cell, entered just after a rising edge
    task automatic put_bit(input logic b);
        rx <= b;
        repeat (div) @(posedge pclk);
    endtask
    // ========================================
    // one frame: start, data lsb first, parity if asked, stop, one idle cell
    task automatic send(input logic [8:0] d, input int nb, input logic [1:0] mode,
                        input logic bad_par, input logic bad_stop);
        logic p;
        // odd mode inverts the even count
        p = (mode == urs_pkg::MODE_8O) ? ~^d[7:0] : ^d[7:0];
        put_bit(1'b0);
        for (int i = 0; i < nb; i++) begin
            put_bit(d[i]);
        end
        // parity only in the two parity formats
        if (mode == urs_pkg::MODE_8E || mode == urs_pkg::MODE_8O) begin
            put_bit(p ^ bad_par);
        end
        put_bit(~bad_stop);
        // idle cell so a low stop is never mistaken for the next start
        put_bit(1'b1);
    endtask
endmodule

/* verification/test_uart_receive_status.sv */
// self-checking bench for the receive-status block
`timescale 1ns/1ns
module test_uart_receive_status;
    // ========================================
    // stimulus and observed signals
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx;
    logic irq;
    // bookkeeping
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // ========================================
    // design and far-side transmitter
    urs_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx(rx), .irq(irq)
    );
    urs_line_src src (.pclk(pclk), .rx(rx));
    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // hang guard, far above the expected run of under two thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run;
        end
    end
    // ========================================
    // reporting
    task complete_run;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // expected status word from its flags
    function automatic logic [31:0] stv(input logic a, i, p, f, o, d);
        logic [31:0] v;
        v = 32'h0;
        v[urs_pkg::BIT_ADDRESS_DETECT_ENABLE] = a;
        v[urs_pkg::BIT_RECEIVER_IDLE_FLAG] = i;
        v[urs_pkg::BIT_PARITY_ERROR_FLAG] = p;
        v[urs_pkg::BIT_FRAMING_ERROR_FLAG] = f;
        v[urs_pkg::BIT_OVERRUN_ERROR_FLAG] = o;
        v[urs_pkg::BIT_RX_DATA_AVAILABLE] = d;
        return v;
    endfunction
    // ========================================
    // apb master, entered just after a rising edge; one idle cycle after each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // ready is judged as sampled at each rising edge; the hang guard ends a lost answer
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        // answer taken at the completing edge, then the request is released
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask
    // ========================================
    // reset values, refused address, idle flag while receiving
    task automatic t_reset_idle;
        logic [31:0] q;
        logic e;
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 0));
        // empty buffer reads zero and pops nothing
        rdc(urs_pkg::ADDR_DATA, 32'h0);
        rdc(urs_pkg::ADDR_DIV, {16'h0000, urs_pkg::DIV_RST});
        rdc(urs_pkg::ADDR_IMASK, 32'h0);
        apb(1'b0, 8'h18, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        wr(urs_pkg::ADDR_DIV, 32'h8);
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_8N});
        fork
            src.send(9'h0A5, 8, urs_pkg::MODE_8N, 1'b0, 1'b0);
            begin
                // mid data bits the receiver is busy
                repeat (30) @(posedge pclk);
                rdc(urs_pkg::ADDR_STA, stv(0, 0, 0, 0, 0, 0));
            end
        join
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h0A5);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 0));
        // event pending but masked, so no interrupt
        check({31'h0, irq}, 32'h0);
        wr(urs_pkg::ADDR_ISTAT, 32'hF);
    endtask
    // ========================================
    // parity and framing flags follow the fifo head
    task automatic t_errors;
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_8E});
        src.send(9'h03C, 8, urs_pkg::MODE_8E, 1'b1, 1'b0);
        src.send(9'h03C, 8, urs_pkg::MODE_8E, 1'b0, 1'b0);
        src.send(9'h081, 8, urs_pkg::MODE_8E, 1'b0, 1'b1);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 1, 0, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h03C);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h03C);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 1, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h081);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 0));
        rdc(urs_pkg::ADDR_ISTAT, 32'hD);
        wr(urs_pkg::ADDR_ISTAT, 32'hF);
        // odd format with correct parity stores a clean character
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_8O});
        src.send(9'h03C, 8, urs_pkg::MODE_8O, 1'b0, 1'b0);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h03C);
        wr(urs_pkg::ADDR_ISTAT, 32'hF);
    endtask
    // ========================================
    // overflow sets the flag, its clearing flushes, interrupt raised and cleared
    task automatic t_overrun;
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_8N});
        wr(urs_pkg::ADDR_IMASK, 32'h2);
        for (int k = 0; k < 5; k++) begin
            src.send(9'h010 + 9'(k), 8, urs_pkg::MODE_8N, 1'b0, 1'b0);
        end
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 1, 1));
        check({31'h0, irq}, 32'h1);
        // writing one must leave the flag alone
        wr(urs_pkg::ADDR_STA, stv(0, 0, 0, 0, 1, 0));
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 1, 1));
        wr(urs_pkg::ADDR_STA, 32'h0);
        rdc(urs_pkg::ADDR_STA, stv(0, 1, 0, 0, 0, 0));
        check({31'h0, irq}, 32'h1);
        wr(urs_pkg::ADDR_ISTAT, 32'hF);
        check({31'h0, irq}, 32'h0);
        // receiver usable again after the flush
        src.send(9'h077, 8, urs_pkg::MODE_8N, 1'b0, 1'b0);
        rdc(urs_pkg::ADDR_DATA, 32'h077);
        wr(urs_pkg::ADDR_IMASK, 32'h0);
        wr(urs_pkg::ADDR_ISTAT, 32'hF);
    endtask
    // ========================================
    // address detect keeps only marked characters, and only in nine-bit format
    task automatic t_addr;
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_9N});
        wr(urs_pkg::ADDR_STA, stv(1, 0, 0, 0, 0, 0));
        src.send(9'h055, 9, urs_pkg::MODE_9N, 1'b0, 1'b0);
        src.send(9'h1AA, 9, urs_pkg::MODE_9N, 1'b0, 1'b0);
        rdc(urs_pkg::ADDR_STA, stv(1, 1, 0, 0, 0, 1));
        rdc(urs_pkg::ADDR_DATA, 32'h1AA);
        rdc(urs_pkg::ADDR_STA, stv(1, 1, 0, 0, 0, 0));
        wr(urs_pkg::ADDR_MODE, {30'h0, urs_pkg::MODE_8N});
        src.send(9'h055, 8, urs_pkg::MODE_8N, 1'b0, 1'b0);
        rdc(urs_pkg::ADDR_DATA, 32'h055);
        wr(urs_pkg::ADDR_STA, 32'h0);
    endtask
    // ========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_idle();
        t_errors();
        t_overrun();
        t_addr();
        complete_run;
    end
endmodule
